// [hdl/asc_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - load entry range into amplifier before conversion
// - round-robin spreads rate over scanned channels
// - interval scan: round-robin or burst per tick
// - software mode: one conversion (whole list in burst) per command
// - hardware pacing from internal or external clock
// - start trigger only for hardware-timed runs
// - buffered: request block moves by dma/interrupt
// - finite mode stops after sample count
// - continuous mode runs until stop command or fifo overrun
// - fifo overwrite raises overrun error
// - host buffer overflow reported in continuous
// - non-buffered: host reads fifo samples directly
// - each entry carries its own terminal mode
module asc_ctrl #(
    parameter int ENTRIES = asc_pkg::ENTRIES_DEF,
    parameter int DATA_W = asc_pkg::DATA_W_DEF,
    parameter int FIFO_DEPTH = asc_pkg::FIFO_DEPTH_DEF,
    parameter int BLOCK = asc_pkg::BLOCK_DEF,
    parameter int HOST_BUF = asc_pkg::HOST_BUF_DEF,
    localparam int IW = $clog2(ENTRIES)
) (
    input wire logic sys_clk,               // 20 MHz system clock
    input wire logic rst_n,                 // async reset, active low
    input wire logic list_wr,               // write one scan list entry
    input wire logic [IW-1:0] list_addr,    // entry written
    input wire logic [5:0] list_chan,       // input channel of entry
    input wire logic [1:0] list_gain,       // gain code of entry
    input wire logic list_bipolar,          // polarity of entry
    input wire logic [1:0] list_mode,       // terminal mode of entry
    input wire logic [IW-1:0] scan_last,    // index of last entry in scan
    input wire logic timing_hw,             // 1 hardware timed, 0 software timed
    input wire logic pace_ext,              // 1 external pacing clock
    input wire logic [15:0] pace_div,       // internal pacing period in cycles
    input wire logic scan_burst,            // 1 whole list per tick
    input wire logic trig_en,               // wait for start trigger
    input wire logic sample_finite,         // 1 finite, 0 continuous
    input wire logic [31:0] sample_total,   // samples in finite mode
    input wire logic buffered,              // 1 block transfer to host
    input wire logic xfer_dma,              // 1 dma, 0 interrupt requests
    input wire logic start_cmd,             // pulse: arm acquisition
    input wire logic stop_cmd,              // pulse: end acquisition
    input wire logic sw_conv,               // pulse: one software conversion
    input wire logic trig_in,               // start trigger, rising edge
    input wire logic ext_clk,               // external pacing, rising edge
    input wire logic conv_done,             // converter result valid
    input wire logic [DATA_W-1:0] conv_data, // converter result
    input wire logic rd_req,                // pulse: take one fifo sample
    input wire logic host_ack,              // pulse: host consumed one sample
    input wire logic clr_err,               // pulse: clear both errors
    output logic [5:0] mux_chan,            // channel to multiplexer
    output logic [1:0] pga_gain,            // gain to amplifier
    output logic pga_bipolar,               // polarity to amplifier
    output logic [1:0] pga_mode,            // terminal mode to input switches
    output logic conv_start,                // pulse: start conversion
    output logic [DATA_W-1:0] rd_data,      // sample read from fifo
    output logic rd_valid,                  // pulse: rd_data valid
    output logic dma_req,                   // level: block ready, dma
    output logic xfer_irq,                  // level: block ready, interrupt
    output logic running,                   // acquisition active
    output logic ovr_err,                   // fifo overrun, sticky
    output logic host_ovf_err               // host buffer overflow, sticky
);
    localparam int FCW = $clog2(FIFO_DEPTH + 1);
    localparam int HW = $clog2(HOST_BUF + 1);
    localparam int SCW = $clog2(asc_pkg::SETTLE_CYC + 1);

    generate
        if (ENTRIES < 2 || (1 << IW) != ENTRIES || BLOCK < 1 || BLOCK > FIFO_DEPTH
            || HOST_BUF < 1) begin : g_bad_param
            $error("asc_ctrl parameters out of range");
        end
    endgenerate

    typedef struct packed {
        asc_pkg::asc_state_t st;
        asc_pkg::asc_entry_t [ENTRIES-1:0] list;
        logic [IW-1:0] idx;
        logic [IW-1:0] last;
        logic [IW-1:0] burst_left;
        logic [SCW-1:0] settle;
        logic [15:0] pace;
        logic [31:0] remaining;
        logic [HW-1:0] host_fill;
        logic trig_q;
        logic ext_q;
        logic cfg_hw;
        logic cfg_ext;
        logic cfg_fin;
        logic cfg_buf;
        logic cfg_dma;
        logic cfg_burst;
        logic ovr_err;
        logic host_ovf_err;
        logic running;
        logic [5:0] mux_chan;
        logic [1:0] pga_gain;
        logic pga_bipolar;
        logic [1:0] pga_mode;
        logic conv_start;
        logic [DATA_W-1:0] rd_data;
        logic rd_valid;
        logic dma_req;
        logic xfer_irq;
    } asc_ctrl_state_t;

    asc_ctrl_state_t s;
    asc_ctrl_state_t next_s;

    logic push;
    logic pop;
    logic fifo_ovr;
    logic [DATA_W-1:0] fifo_dout;
    logic [FCW-1:0] fifo_cnt;

    assign push = (s.st == asc_pkg::ST_CONV) && conv_done;
    // direct single-sample reads from the fifo head
    assign pop = rd_req && (fifo_cnt != '0);

    asc_fifo #(
        .W(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .push(push),
        .din(conv_data),
        .pop(pop),
        .dout(fifo_dout),
        .count(fifo_cnt),
        .ovr(fifo_ovr)
    );

    always_comb begin
        logic tick;
        logic [IW-1:0] nxt;
        asc_pkg::asc_entry_t e;
        tick = 1'b0;
        nxt = '0;
        e = '0;
        next_s = s;
        next_s.conv_start = 1'b0;
        next_s.rd_valid = 1'b0;
        next_s.trig_q = trig_in;
        next_s.ext_q = ext_clk;
        if (list_wr) begin
            next_s.list[list_addr] = {list_chan, list_gain, list_bipolar, list_mode};
        end
        // pace source is internal divider or external edge
        if (!s.cfg_hw) begin
            // software timing, each command is one tick
            tick = sw_conv;
        end else if (s.cfg_ext) begin
            tick = ext_clk && !s.ext_q;
        end else begin
            tick = (s.pace == asc_pkg::PACE_RST);
        end
        if (s.st == asc_pkg::ST_IDLE || s.pace == asc_pkg::PACE_RST) begin
            next_s.pace = (pace_div == asc_pkg::PACE_RST) ? asc_pkg::PACE_RST
                                                          : pace_div - asc_pkg::PACE_ONE;
        end else begin
            next_s.pace = s.pace - asc_pkg::PACE_ONE;
        end
        // wrap to the first entry after the last
        nxt = (s.idx == s.last) ? '0 : s.idx + 1'b1;

        unique case (s.st)
            asc_pkg::ST_IDLE: begin
                if (start_cmd && !s.ovr_err && !(sample_finite && sample_total == '0)) begin
                    next_s.cfg_hw = timing_hw;
                    next_s.cfg_ext = pace_ext;
                    next_s.cfg_fin = sample_finite;
                    next_s.cfg_buf = buffered;
                    next_s.cfg_dma = xfer_dma;
                    next_s.cfg_burst = scan_burst;
                    next_s.last = scan_last;
                    next_s.idx = '0;
                    next_s.remaining = sample_total;
                    next_s.host_fill = '0;
                    // trigger wait only for hardware timing
                    next_s.st = (timing_hw && trig_en) ? asc_pkg::ST_ARM : asc_pkg::ST_WAIT;
                end
            end
            asc_pkg::ST_ARM: begin
                if (trig_in && !s.trig_q) begin
                    next_s.st = asc_pkg::ST_WAIT;
                end
            end
            asc_pkg::ST_WAIT: begin
                if (tick) begin
                    // burst runs the whole list, else one entry per tick
                    next_s.burst_left = s.cfg_burst ? s.last : '0;
                    next_s.st = asc_pkg::ST_SETTLE;
                end
            end
            asc_pkg::ST_SETTLE: begin
                if (s.settle == '0) begin
                    next_s.conv_start = 1'b1;
                    next_s.st = asc_pkg::ST_CONV;
                end else begin
                    next_s.settle = s.settle - 1'b1;
                end
            end
            asc_pkg::ST_CONV: begin
                if (conv_done) begin
                    next_s.idx = nxt;
                    if (s.cfg_fin) begin
                        next_s.remaining = s.remaining - 32'h1;
                    end
                    // finite run ends on its last sample
                    if (s.cfg_fin && s.remaining == 32'h1) begin
                        next_s.st = asc_pkg::ST_IDLE;
                    end else if (s.burst_left != '0) begin
                        next_s.burst_left = s.burst_left - 1'b1;
                        next_s.st = asc_pkg::ST_SETTLE;
                    end else begin
                        // round-robin waits a full tick per channel
                        next_s.st = asc_pkg::ST_WAIT;
                    end
                end
            end
            default: begin
                next_s.st = asc_pkg::ST_IDLE;
            end
        endcase

        // only stop or a fifo overrun ends a continuous run
        if (stop_cmd || fifo_ovr) begin
            next_s.st = asc_pkg::ST_IDLE;
            next_s.conv_start = 1'b0;
        end
        // amplifier takes the entry's range before conversion
        if (next_s.st == asc_pkg::ST_SETTLE && s.st != asc_pkg::ST_SETTLE) begin
            e = s.list[next_s.idx];
            next_s.mux_chan = e.chan;
            next_s.pga_gain = e.gain;
            next_s.pga_bipolar = e.bipolar;
            next_s.pga_mode = e.mode;
            next_s.settle = SCW'(asc_pkg::SETTLE_CYC);
        end

        // sticky overrun, set wins over clear
        if (fifo_ovr) begin
            next_s.ovr_err = 1'b1;
        end else if (clr_err) begin
            next_s.ovr_err = 1'b0;
        end
        if (clr_err) begin
            next_s.host_ovf_err = 1'b0;
        end
        // host buffer occupancy; overflow in continuous mode
        if (pop && s.cfg_buf && !(host_ack && s.host_fill != '0)) begin
            if (s.host_fill == HW'(HOST_BUF)) begin
                next_s.host_ovf_err = !s.cfg_fin || s.host_ovf_err;
            end else begin
                next_s.host_fill = s.host_fill + 1'b1;
            end
        end else if (!(pop && s.cfg_buf) && host_ack && s.host_fill != '0) begin
            next_s.host_fill = s.host_fill - 1'b1;
        end

        if (pop) begin
            next_s.rd_data = fifo_dout;
            next_s.rd_valid = 1'b1;
        end
        // block ready requests by dma or interrupt
        next_s.dma_req = next_s.cfg_buf && next_s.cfg_dma && (fifo_cnt >= FCW'(BLOCK));
        next_s.xfer_irq = next_s.cfg_buf && !next_s.cfg_dma && (fifo_cnt >= FCW'(BLOCK));
        next_s.running = (next_s.st != asc_pkg::ST_IDLE);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign mux_chan = s.mux_chan;
    assign pga_gain = s.pga_gain;
    assign pga_bipolar = s.pga_bipolar;
    assign pga_mode = s.pga_mode;
    assign conv_start = s.conv_start;
    assign rd_data = s.rd_data;
    assign rd_valid = s.rd_valid;
    assign dma_req = s.dma_req;
    assign xfer_irq = s.xfer_irq;
    assign running = s.running;
    assign ovr_err = s.ovr_err;
    assign host_ovf_err = s.host_ovf_err;

    // checks
    localparam int A_CONV_DLY = asc_pkg::SETTLE_CYC + 2;
    localparam int A_CONV_MIN = A_CONV_DLY - 1;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_done;
        s.st == asc_pkg::ST_CONV && conv_done && !stop_cmd && !fifo_ovr;
    endsequence
    sequence s_not_last;
        !(s.cfg_fin && s.remaining == 32'h1);
    endsequence

    a_pga_load: assert property (s.st == asc_pkg::ST_SETTLE |->
        {mux_chan, pga_gain, pga_bipolar, pga_mode} == s.list[s.idx])
        else $error("amplifier setting differs from scan entry");
    a_sw_one_conv: assert property (!s.cfg_hw && s.st == asc_pkg::ST_WAIT && sw_conv
        && !stop_cmd && !fifo_ovr |-> ##[A_CONV_MIN:A_CONV_DLY] conv_start)
        else $error("software command did not start one conversion");
    a_trig_hw_only: assert property (s.st == asc_pkg::ST_ARM |-> s.cfg_hw)
        else $error("trigger wait in software-timed run");
    a_ext_pace: assert property (s.cfg_hw && s.cfg_ext && s.st == asc_pkg::ST_WAIT
        && $rose(ext_clk) && !stop_cmd && !fifo_ovr |=> s.st == asc_pkg::ST_SETTLE)
        else $error("external pace edge ignored");
    a_burst_chain: assert property (s_done ##0 s_not_last ##0 s.burst_left != '0
        |=> s.st == asc_pkg::ST_SETTLE)
        else $error("burst did not continue to next entry");
    a_rr_wait: assert property (s_done ##0 s_not_last ##0 !s.cfg_burst
        |=> s.st == asc_pkg::ST_WAIT)
        else $error("round-robin converted twice per tick");
    a_list_wrap: assert property (s_done ##0 s.idx == s.last |=> s.idx == '0)
        else $error("scan index did not wrap");
    a_finite_stop: assert property (s_done ##0 s.cfg_fin && s.remaining == 32'h1
        |=> s.st == asc_pkg::ST_IDLE && !running)
        else $error("finite run did not stop at count");
    a_cont_run: assert property (!s.cfg_fin && s.st != asc_pkg::ST_IDLE && !stop_cmd
        && !fifo_ovr |=> s.st != asc_pkg::ST_IDLE)
        else $error("continuous run stopped without command");
    a_ovr_halt: assert property ($rose(ovr_err) |-> s.st == asc_pkg::ST_IDLE)
        else $error("overrun did not halt acquisition");
    a_ovr_sticky: assert property (ovr_err && !clr_err |=> ovr_err)
        else $error("overrun flag dropped without clear");
    a_host_ovf: assert property (pop && s.cfg_buf && !s.cfg_fin && !host_ack
        && s.host_fill == HW'(HOST_BUF) |=> host_ovf_err)
        else $error("host buffer overflow not reported");
    // a start may latch a new transfer mode, so requests follow the new one
    a_blk_req: assert property (s.cfg_buf && fifo_cnt >= FCW'(BLOCK) && $stable(fifo_cnt)
        && !start_cmd |=> dma_req || xfer_irq)
        else $error("full block not requested");
    a_nobuf_direct: assert property (!s.cfg_buf |-> !dma_req && !xfer_irq)
        else $error("block request in non-buffered mode");

endmodule

`default_nettype wire

// [hdl/asc_pkg.sv]
package asc_pkg;

    localparam int CLK_HZ = 20_000_000;
    // allowance for the gain amplifier to settle after a range change
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    localparam int ENTRIES_DEF = 16;
    localparam int DATA_W_DEF = 16;
    localparam int FIFO_DEPTH_DEF = 16;
    localparam int BLOCK_DEF = 8;
    localparam int HOST_BUF_DEF = 1024;

    localparam logic [15:0] PACE_RST = 16'h0000;
    localparam logic [15:0] PACE_ONE = 16'h0001;

    localparam logic [1:0] MODE_DIFF = 2'h0;
    localparam logic [1:0] MODE_RSE = 2'h1;
    localparam logic [1:0] MODE_NRSE = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ARM = 3'h1,
        ST_WAIT = 3'h2,
        ST_SETTLE = 3'h3,
        ST_CONV = 3'h4
    } asc_state_t;

    typedef struct packed {
        logic [5:0] chan;
        logic [1:0] gain;
        logic bipolar;
        logic [1:0] mode;
    } asc_entry_t;

endpackage

// [hdl/asc_fifo.sv]
`timescale 1ns/1ns
`default_nettype none

module asc_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16,
    localparam int CW = $clog2(DEPTH + 1)
) (
    input wire logic sys_clk,          // system clock
    input wire logic rst_n,            // async reset, active low
    input wire logic push,             // write one sample
    input wire logic [W-1:0] din,      // sample written
    input wire logic pop,              // remove head sample
    output logic [W-1:0] dout,         // head sample
    output logic [CW-1:0] count,       // samples held
    output logic ovr                   // pulse: oldest sample overwritten
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("asc_fifo depth must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
        logic ovr;
    } asc_fifo_state_t;

    asc_fifo_state_t s;
    asc_fifo_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.ovr = 1'b0;
        if (push && pop && s.cnt != '0) begin
            next_s.mem[s.wr] = din;
            next_s.wr = s.wr + 1'b1;
            next_s.rd = s.rd + 1'b1;
        end else if (push) begin
            next_s.mem[s.wr] = din;
            next_s.wr = s.wr + 1'b1;
            // full fifo drops its oldest sample
            if (s.cnt == CW'(DEPTH)) begin
                next_s.rd = s.rd + 1'b1;
                next_s.ovr = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end else if (pop && s.cnt != '0) begin
            next_s.rd = s.rd + 1'b1;
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.mem[s.rd];
    assign count = s.cnt;
    assign ovr = s.ovr;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_fifo_overrun: assert property (push && !pop && s.cnt == CW'(DEPTH) |=> ovr && s.cnt == CW'(DEPTH))
        else $error("overwrite of full fifo not flagged");

endmodule

`default_nettype wire

// [test/asc_adc_model.sv]
`timescale 1ns/1ns
`default_nettype none

module asc_adc_model (
    input wire logic sys_clk,      // system clock
    input wire logic rst_n,        // async reset, active low
    input wire logic slow,         // 1 stretch conversion time
    input wire logic conv_start,   // pulse: begin conversion
    output logic conv_done,        // pulse: result valid
    output logic [15:0] conv_data  // result, scrambled between results
);
    logic [7:0] pipe;
    logic [7:0] seq;
    logic fire;

    assign fire = slow ? pipe[6] : pipe[1];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pipe <= 8'h00;
            seq <= 8'h00;
            conv_done <= 1'b0;
            conv_data <= 16'h0000;
        end else begin
            pipe <= {pipe[6:0], conv_start};
            conv_done <= fire;
            // never hold a stale result, so a late sample cannot pass by luck
            conv_data <= fire ? {8'h5a, seq} : ~conv_data;
            seq <= seq + {7'h00, fire};
        end
    end
endmodule

`default_nettype wire

// [test/tb_ai_scan_acquisition_control.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_ai_scan_acquisition_control;
    logic sys_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic list_wr = 1'b0, list_bipolar = 1'b0, timing_hw = 1'b0, pace_ext = 1'b0;
    logic scan_burst = 1'b0, trig_en = 1'b0, sample_finite = 1'b0, buffered = 1'b0;
    logic xfer_dma = 1'b0, start_cmd = 1'b0, stop_cmd = 1'b0, sw_conv = 1'b0;
    logic trig_in = 1'b0, ext_clk = 1'b0, rd_req = 1'b0, host_ack = 1'b0, clr_err = 1'b0;
    logic [3:0] list_addr = 4'h0, scan_last = 4'h0;
    logic [5:0] list_chan = 6'h00;
    logic [1:0] list_gain = 2'h0, list_mode = 2'h0;
    logic [15:0] pace_div = 16'h0000;
    logic [31:0] sample_total = 32'h00000000;
    logic conv_done, conv_start, rd_valid, dma_req, xfer_irq, running, ovr_err, host_ovf_err;
    logic [15:0] conv_data, rd_data;
    logic [5:0] mux_chan;
    logic [1:0] pga_gain, pga_mode;
    logic pga_bipolar;
    asc_pkg::asc_entry_t ent [2];
    int fails = 0, check_count = 0;

    always #25 sys_clk = ~sys_clk;

    asc_ctrl #(.HOST_BUF(4)) i_dut (.sys_clk, .rst_n, .list_wr, .list_addr, .list_chan,
        .list_gain, .list_bipolar, .list_mode, .scan_last, .timing_hw, .pace_ext, .pace_div,
        .scan_burst, .trig_en, .sample_finite, .sample_total, .buffered, .xfer_dma,
        .start_cmd, .stop_cmd, .sw_conv, .trig_in, .ext_clk, .conv_done, .conv_data,
        .rd_req, .host_ack, .clr_err, .mux_chan, .pga_gain, .pga_bipolar, .pga_mode,
        .conv_start, .rd_data, .rd_valid, .dma_req, .xfer_irq, .running, .ovr_err,
        .host_ovf_err);

    asc_adc_model i_adc (.sys_clk, .rst_n, .slow, .conv_start, .conv_done, .conv_data);

    task automatic stop_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return conv_start;
            1: return dma_req;
            2: return xfer_irq;
            default: return ovr_err;
        endcase
    endfunction

    task automatic wait_for(input int s, input int lim, output int n);
        n = 0;
        while (pick(s) !== 1'b1) begin
            tick();
            n++;
            if (n > lim) begin
                fails++;
                $display("[ERR] wait %0d expected 1 seen timeout", s);
                stop_test();
            end
        end
    endtask

    task automatic count_cs(input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            tick();
            c += conv_start;
        end
    endtask

    task automatic wr_entry(input logic [3:0] a, input asc_pkg::asc_entry_t e);
        {list_chan, list_gain, list_bipolar, list_mode} = e;
        list_addr = a;
        list_wr = 1'b1;
        tick();
        list_wr = 1'b0;
    endtask

    task automatic go();
        start_cmd = 1'b1;
        tick();
        start_cmd = 1'b0;
        tick();
        chk("running", 1, running);
    endtask

    task automatic pop(input int k);
        rd_req = 1'b1;
        tick(k);
        rd_req = 1'b0;
        tick();
    endtask

    task automatic t_sw_scan();
        int n;
        int c;
        wr_entry(4'h0, ent[0]);
        wr_entry(4'h1, ent[1]);
        scan_last = 4'h1;
        sample_finite = 1'b1;
        sample_total = 32'h00000003;
        go();
        for (int i = 0; i < 3; i++) begin
            sw_conv = 1'b1;
            tick();
            sw_conv = 1'b0;
            wait_for(0, 100, n);
            chk("settle cycles", asc_pkg::SETTLE_CYC + 1, n);
            chk("amp setup", ent[i % 2], {mux_chan, pga_gain, pga_bipolar, pga_mode});
            count_cs(30, c);
            chk("extra starts", 0, c);
        end
        chk("wrapped channel", ent[0].chan, mux_chan);
        chk("finite stop", 0, running);
    endtask

    task automatic t_read();
        rd_req = 1'b1;
        for (int i = 0; i < 3; i++) begin
            tick();
            chk("read valid", 1, rd_valid);
            chk("read data", 16'h5a00 + i, rd_data);
        end
        // fourth request meets an empty fifo
        tick();
        rd_req = 1'b0;
        chk("empty read", 0, rd_valid);
        tick();
    endtask

    task automatic t_pace();
        int n;
        timing_hw = 1'b1;
        pace_div = 16'h0032;
        sample_finite = 1'b0;
        buffered = 1'b1;
        xfer_dma = 1'b1;
        go();
        wait_for(0, 200, n);
        tick();
        wait_for(0, 200, n);
        chk("tick spacing", 49, n);
        chk("next channel", ent[1].chan, mux_chan);
        wait_for(1, 1000, n);
        chk("irq with dma", 0, xfer_irq);
        chk("still running", 1, running);
        stop_cmd = 1'b1;
        tick();
        stop_cmd = 1'b0;
        tick();
        chk("stopped", 0, running);
    endtask

    task automatic t_trig_burst();
        int n;
        pace_ext = 1'b1;
        trig_en = 1'b1;
        scan_burst = 1'b1;
        sample_finite = 1'b1;
        sample_total = 32'h00000002;
        buffered = 1'b0;
        slow = 1'b1;
        go();
        repeat (2) begin
            ext_clk = 1'b1;
            tick(2);
            ext_clk = 1'b0;
            tick(2);
        end
        count_cs(30, n);
        chk("start before trigger", 0, n);
        trig_in = 1'b1;
        tick(2);
        trig_in = 1'b0;
        ext_clk = 1'b1;
        tick(2);
        ext_clk = 1'b0;
        wait_for(0, 100, n);
        chk("burst first", ent[0].chan, mux_chan);
        tick();
        wait_for(0, 100, n);
        chk("burst second", ent[1].chan, mux_chan);
        slow = 1'b0;
        tick(20);
    endtask

    task automatic t_ovr();
        int n;
        pace_ext = 1'b0;
        trig_en = 1'b0;
        scan_burst = 1'b0;
        sample_finite = 1'b0;
        go();
        wait_for(3, 2000, n);
        tick(2);
        chk("halted on overrun", 0, running);
        start_cmd = 1'b1;
        tick();
        start_cmd = 1'b0;
        tick(2);
        chk("start refused", 0, running);
        chk("overrun sticky", 1, ovr_err);
        clr_err = 1'b1;
        tick();
        clr_err = 1'b0;
        tick();
        chk("overrun cleared", 0, ovr_err);
    endtask

    task automatic t_host_ovf();
        int n;
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick();
        buffered = 1'b1;
        xfer_dma = 1'b0;
        go();
        wait_for(2, 1000, n);
        chk("dma with irq", 0, dma_req);
        pop(4);
        host_ack = 1'b1;
        tick();
        host_ack = 1'b0;
        pop(1);
        tick();
        chk("no overflow", 0, host_ovf_err);
        pop(1);
        tick();
        chk("overflow", 1, host_ovf_err);
    endtask

    initial begin
        ent[0] = {6'h05, 2'h3, 1'b0, asc_pkg::MODE_DIFF};
        ent[1] = {6'h2a, 2'h1, 1'b1, asc_pkg::MODE_NRSE};
        tick(10);
        rst_n = 1'b1;
        tick();
        t_sw_scan();
        t_read();
        t_pace();
        t_trig_burst();
        t_ovr();
        t_host_ovf();
        stop_test();
    end
endmodule

`default_nettype wire
